// >>> hdl/adc_clk_div.sv
`timescale 1ns/1ns
module adc_clk_div
  import adc_regs_pkg::*;
(
  input  wire logic       pclk,     // system clock
  input  wire logic       presetn,  // async reset, active low
  input  wire logic [2:0] div_sel,  // 0 = every cycle .. 6 = every 64th
  output logic            tick      // one-cycle converter clock enable
);
  logic [5:0] cnt_ff;
  logic [5:0] mask;

  // code 111 is undefined; treated as the slowest rate
  assign mask = (div_sel >= 3'h6) ? 6'h3F : 6'((7'h01 << div_sel) - 7'h01);
  assign tick = ((cnt_ff & mask) == 6'h00);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= cnt_ff + 6'h01;
    end
  end
endmodule : adc_clk_div

// >>> hdl/adc_result_and_control_regs.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module adc_result_and_control_regs
  import adc_regs_pkg::*;
(
  input  wire logic        pclk,         // system clock, 10 MHz
  input  wire logic        presetn,      // async reset, active low
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction
  input  wire logic [11:0] paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error, unmapped address
  input  wire logic        pwm_trigger,  // pwm start request, same clock, pulse
  input  wire logic [9:0]  core_data,    // converter core result
  output logic      [2:0]  channel_select,       // analog mux select
  output logic             converter_power_off,  // core power down
  output logic             core_reset,           // core held reset
  output logic             conv_start,           // core start pulse
  output logic             irq                   // level interrupt
);
  logic [7:0] ctrl0_ff;
  logic [7:0] ctrl1_ff;
  logic [1:0] ctrl2_ff;
  logic [7:0] delay_ff;
  logic [9:0] lbound_ff;
  logic [9:0] ubound_ff;
  logic [9:0] result_ff;
  logic [1:0] stat_ff;
  logic [1:0] irq_en_ff;
  logic [7:0] dcnt_ff;
  logic [3:0] tcnt_ff;
  logic       busy_ff;
  logic       start_q_ff;
  logic       conv_q_ff;
  logic       done_pulse;
  logic       bound_hit;
  logic [9:0] res_nxt;
  logic       tick;
  logic       wr_en;
  logic       rd_ok;
  logic       sw_fire;
  logic       hw_fire;
  logic [31:0] nxt_prdata;
  conv_state_t state_ff;

  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign channel_select      = ctrl0_ff[2:0];
  assign converter_power_off = ctrl0_ff[CTRL0_OFF_BIT];
  assign core_reset          = ctrl0_ff[CTRL0_START_BIT];
  assign conv_start          = (state_ff == ST_CONV) && !conv_q_ff;
  assign irq = |(stat_ff & irq_en_ff);

  adc_clk_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .div_sel (ctrl1_ff[2:0]),
    .tick    (tick)
  );

  always_comb begin
    rd_ok = 1'b1;
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      OFF_RES_LO:   nxt_prdata = {24'h0, result_ff[7:0]};
      OFF_RES_HI:   nxt_prdata = {30'h0, result_ff[9:8]};
      // busy shows the held start bit at once, before busy_ff catches up
      OFF_CTRL0:    nxt_prdata = {24'h0, ctrl0_ff[7], busy_ff | ctrl0_ff[7],
                                  ctrl0_ff[5], 2'b00, ctrl0_ff[2:0]};
      OFF_CTRL1:    nxt_prdata = {24'h0, ctrl1_ff};
      OFF_CTRL2:    nxt_prdata = {30'h0, ctrl2_ff};
      OFF_DELAY:    nxt_prdata = {24'h0, delay_ff};
      OFF_LB_LO:    nxt_prdata = {24'h0, lbound_ff[7:0]};
      OFF_LB_HI:    nxt_prdata = {30'h0, lbound_ff[9:8]};
      OFF_UB_LO:    nxt_prdata = {24'h0, ubound_ff[7:0]};
      OFF_UB_HI:    nxt_prdata = {30'h0, ubound_ff[9:8]};
      OFF_IRQ_STAT: nxt_prdata = {30'h0, stat_ff};
      OFF_IRQ_EN:   nxt_prdata = {30'h0, irq_en_ff};
      OFF_IRQ_CLR:  nxt_prdata = 32'h0000_0000;
      default:      rd_ok = 1'b0;
    endcase
  end

  assign prdata  = nxt_prdata;
  assign pslverr = psel && penable && !rd_ok;

  // writes to the result bytes decode but are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_ff  <= CTRL0_RESET;
      ctrl1_ff  <= CTRL1_RESET;
      ctrl2_ff  <= 2'h0;
      delay_ff  <= 8'h00;
      lbound_ff <= 10'h000;
      ubound_ff <= 10'h000;
      irq_en_ff <= 2'h0;
    end else if (wr_en) begin
      case (paddr)
        OFF_CTRL0: ctrl0_ff  <= {pwdata[7], 1'b0, pwdata[5], 2'b00, pwdata[2:0]};
        OFF_CTRL1: ctrl1_ff  <= pwdata[7:0];
        OFF_CTRL2: ctrl2_ff  <= pwdata[1:0];
        OFF_DELAY: delay_ff  <= pwdata[7:0];
        OFF_LB_LO: lbound_ff[7:0] <= pwdata[7:0];
        OFF_LB_HI: lbound_ff[9:8] <= pwdata[1:0];
        OFF_UB_LO: ubound_ff[7:0] <= pwdata[7:0];
        OFF_UB_HI: ubound_ff[9:8] <= pwdata[1:0];
        OFF_IRQ_EN: irq_en_ff <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q_ff <= 1'b0;
    end else begin
      start_q_ff <= ctrl0_ff[CTRL0_START_BIT];
    end
  end

  // software start fires on the falling edge of the start bit
  assign sw_fire = start_q_ff && !ctrl0_ff[CTRL0_START_BIT] &&
                   !ctrl1_ff[CTRL1_TRIG_SEL];
  assign hw_fire = pwm_trigger && ctrl1_ff[CTRL1_TRIG_SEL];

  // conversion sequencer; the analog core is modelled by a tick count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      dcnt_ff  <= 8'h00;
      tcnt_ff  <= 4'h0;
    end else if (ctrl0_ff[CTRL0_START_BIT] || ctrl0_ff[CTRL0_OFF_BIT]) begin
      state_ff <= ST_HOLD;
      tcnt_ff  <= 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE, ST_HOLD: begin
          if (sw_fire) begin
            state_ff <= ST_CONV;
            tcnt_ff  <= CONV_TICKS;
          end else if (hw_fire) begin
            if (ctrl1_ff[CTRL1_DLY_EN] && delay_ff != 8'h00) begin
              state_ff <= ST_DELAY;
              dcnt_ff  <= delay_ff;
            end else begin
              state_ff <= ST_CONV;
              tcnt_ff  <= CONV_TICKS;
            end
          end
        end
        ST_DELAY: begin
          if (dcnt_ff == 8'h01) begin
            state_ff <= ST_CONV;
            tcnt_ff  <= CONV_TICKS;
          end
          dcnt_ff <= dcnt_ff - 8'h01;
        end
        ST_CONV: begin
          if (tick) begin
            if (tcnt_ff == 4'h1) begin
              state_ff <= ST_IDLE;
            end
            tcnt_ff <= tcnt_ff - 4'h1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // marks the first cycle of each conversion for the core start strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_q_ff <= 1'b0;
    end else begin
      conv_q_ff <= (state_ff == ST_CONV);
    end
  end

  assign done_pulse = (state_ff == ST_CONV) && tick && (tcnt_ff == 4'h1) &&
                      !ctrl0_ff[CTRL0_START_BIT] && !ctrl0_ff[CTRL0_OFF_BIT];

  // busy is one from reset, while held, and during a software-started conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b1;
    end else if (ctrl0_ff[CTRL0_START_BIT]) begin
      busy_ff <= 1'b1;
    end else if (done_pulse) begin
      busy_ff <= 1'b0;
    end
  end

  assign res_nxt = core_data;

  // result not cleared at reset since it is undefined until first conversion
  always_ff @(posedge pclk) begin
    if (done_pulse) begin
      result_ff <= res_nxt;
    end
  end

  always_comb begin
    case ({ctrl1_ff[CTRL1_HI_EN], ctrl1_ff[CTRL1_LO_EN]})
      2'b00:   bound_hit = (res_nxt > lbound_ff) && (res_nxt < ubound_ff);
      2'b01:   bound_hit = (res_nxt <= lbound_ff);
      2'b10:   bound_hit = (res_nxt >= ubound_ff);
      default: bound_hit = (res_nxt <= lbound_ff) || (res_nxt >= ubound_ff);
    endcase
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_ff <= 2'h0;
    end else begin
      stat_ff <= (stat_ff & ~((wr_en && paddr == OFF_IRQ_CLR) ? pwdata[1:0] : 2'h0)) |
                 {done_pulse && bound_hit, done_pulse};
    end
  end

  a_busy_during_hold: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ctrl0_ff[CTRL0_START_BIT]) |-> busy_ff)
    else $error("busy low while start bit held");

  a_done_clears_busy: assert property (@(posedge pclk) disable iff (!presetn)
    done_pulse |=> !busy_ff)
    else $error("busy still set after conversion end");

  a_result_loaded: assert property (@(posedge pclk) disable iff (!presetn)
    done_pulse |=> result_ff == $past(core_data))
    else $error("result not loaded at conversion end");

  a_hi_byte_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && paddr == OFF_RES_HI) |-> prdata[31:2] == 30'h0)
    else $error("high result byte upper bits not zero");

  a_bound_irq_set: assert property (@(posedge pclk) disable iff (!presetn)
    (done_pulse && bound_hit) |=> stat_ff[IRQ_BOUND_BIT])
    else $error("boundary status not set");

  a_delay_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == ST_IDLE && hw_fire && ctrl1_ff[CTRL1_DLY_EN] && delay_ff != 8'h00 &&
     !ctrl0_ff[CTRL0_START_BIT] && !ctrl0_ff[CTRL0_OFF_BIT] && !wr_en)
    |=> state_ff == ST_DELAY)
    else $error("delayed start did not wait");

  a_channel_route: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFF_CTRL0) |=> channel_select == $past(pwdata[2:0]))
    else $error("channel select not routed");

  a_bound_assemble: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFF_UB_HI) |=> ubound_ff[9:8] == $past(pwdata[1:0]))
    else $error("upper bound high bits not stored");

  a_irq_clear_all: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == OFF_IRQ_CLR && pwdata[1:0] == 2'h3 && !done_pulse) |=> !irq)
    else $error("interrupt still high after full clear");
endmodule : adc_result_and_control_regs

// >>> pkg/adc_regs_pkg.sv
// Summary of operation
// - One of six external inputs or the amplified current-sense input is routed to the converter by a 3-bit channel select.
// - A conversion yields 10 bits: bits 7..0 in the low result byte, bits 9..8 in bits 1..0 of the high result byte.
// - Bits 7..2 of the high result byte are not implemented and read zero.
// - Both result bytes are read-only and writes to them do nothing; their value before the first conversion is undefined.
// - Once a conversion completes the result bytes hold the value with no further access sequence needed.
// - Each result is compared with an upper and a lower limit and the converter interrupt is raised when the selected condition holds.
// - A PWM-triggered start is held off by the count in the delay register.
// - Software starts a conversion with start bit low, high, low; while high the converter is held reset and busy reads one.
// - The busy flag reads one during a conversion and zero once it has ended, and software cannot write it; here a PWM-triggered start does not set it.
// - Channel codes 000 to 101 pick external inputs 0 to 5, 110 picks the amplifier, 111 is undefined.
package adc_regs_pkg;
  localparam logic [11:0] OFF_RES_LO   = 12'h000;
  localparam logic [11:0] OFF_RES_HI   = 12'h004;
  localparam logic [11:0] OFF_CTRL0    = 12'h008;
  localparam logic [11:0] OFF_CTRL1    = 12'h00C;
  localparam logic [11:0] OFF_CTRL2    = 12'h010;
  localparam logic [11:0] OFF_DELAY    = 12'h014;
  localparam logic [11:0] OFF_LB_LO    = 12'h018;
  localparam logic [11:0] OFF_LB_HI    = 12'h01C;
  localparam logic [11:0] OFF_UB_LO    = 12'h020;
  localparam logic [11:0] OFF_UB_HI    = 12'h024;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h028;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h02C;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h030;
  // control 0 fields
  localparam int CTRL0_START_BIT = 7;
  localparam int CTRL0_BUSY_BIT  = 6;
  localparam int CTRL0_OFF_BIT   = 5;
  // control 1 fields
  localparam int CTRL1_TRIG_SEL  = 7;
  localparam int CTRL1_DLY_EN    = 6;
  localparam int CTRL1_HI_EN     = 4;
  localparam int CTRL1_LO_EN     = 3;
  // interrupt status bits
  localparam int IRQ_DONE_BIT    = 0;
  localparam int IRQ_BOUND_BIT   = 1;
  localparam logic [7:0] CTRL0_RESET = 8'h60;
  localparam logic [7:0] CTRL1_RESET = 8'h00;
  localparam logic [2:0] CHAN_AMP    = 3'h6;
  // cycles the modelled core takes per conversion, in converter clock ticks
  localparam logic [3:0] CONV_TICKS  = 4'hC;
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_DELAY, ST_CONV} conv_state_t;
endpackage : adc_regs_pkg

// >>> tb/adc_result_and_control_regs_test.sv
`timescale 1ns/1ns
module adc_result_and_control_regs_test;
  import adc_regs_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pwm_trigger = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, power_off, core_reset, conv_start, irq;
  logic [2:0]  chan;
  logic [9:0]  core_data;
  int          miscompares = 0, samples_checked = 0, cyc = 0, starts = 0;
  always #50 pclk = ~pclk;
  adc_result_and_control_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_trigger(pwm_trigger), .core_data(core_data),
    .channel_select(chan), .converter_power_off(power_off), .core_reset(core_reset),
    .conv_start(conv_start), .irq(irq));
  conv_core_model i_core (.pclk(pclk), .chan(chan), .power_off(power_off),
    .core_data(core_data));
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  always @(posedge pclk) begin
    cyc++;
    if (conv_start === 1'b1) starts++;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic conv(input logic [2:0] ch);
    logic [9:0] e;
    int n;
    int s0;
    e = {ch, 7'h2A};
    n = 0;
    s0 = starts;
    apb(1, OFF_CTRL0, {29'h0, ch});
    apb(1, OFF_CTRL0, {24'h0, 5'h10, ch});
    @(posedge pclk);
    chk("core_reset", 1, core_reset);
    apb(0, OFF_CTRL0, 0);
    chk("busy held", 1, rd[CTRL0_BUSY_BIT]);
    apb(1, OFF_CTRL0, {29'h0, ch});
    do begin
      apb(0, OFF_CTRL0, 0);
      n++;
    end while (rd[CTRL0_BUSY_BIT] !== 1'b0 && n < 100);
    chk("busy end", 0, rd[CTRL0_BUSY_BIT]);
    chk("channel_select", ch, chan);
    apb(0, OFF_RES_LO, 0);
    chk("result low", e[7:0], rd);
    apb(0, OFF_RES_HI, 0);
    chk("result high", e[9:8], rd);
    chk("conv_start", s0 + 1, starts);
  endtask : conv
  task automatic t_reset();
    apb(0, OFF_CTRL0, 0);
    chk("control0 reset", 32'h60, rd);
    apb(0, OFF_CTRL1, 0);
    chk("control1 reset", 0, rd);
    chk("power off", 1, power_off);
  endtask : t_reset
  task automatic t_channels();
    for (int i = 0; i < 7; i++) conv(i[2:0]);
  endtask : t_channels
  task automatic t_regs();
    apb(1, OFF_RES_LO, 32'hFF);
    apb(0, OFF_RES_LO, 0);
    chk("result low ro", 32'h2A, rd);
    apb(1, OFF_RES_HI, 32'hFF);
    apb(0, OFF_RES_HI, 0);
    chk("result high ro", 32'h03, rd);
    apb(1, OFF_CTRL0, 32'h40);
    apb(0, OFF_CTRL0, 0);
    chk("busy not writable", 0, rd);
    apb(1, OFF_LB_HI, 32'hFD);
    apb(0, OFF_LB_HI, 0);
    chk("bound high bits", 32'h01, rd);
    apb(0, 12'hFFC, 0);
    chk("pslverr", 1, err);
  endtask : t_regs
  task automatic t_bounds();
    logic [9:0] lb, ub, r;
    logic hit;
    r = 10'h12A;
    for (int s = 0; s < 2; s++) begin
      lb = s ? 10'h100 : r;
      ub = s ? 10'h200 : r;
      for (int m = 0; m < 4; m++) begin
        hit = (m == 0) ? (lb < r && r < ub) : (m == 1) ? (r <= lb) :
              (m == 2) ? (r >= ub) : (r <= lb || r >= ub);
        apb(1, OFF_LB_LO, lb[7:0]);
        apb(1, OFF_LB_HI, lb[9:8]);
        apb(1, OFF_UB_LO, ub[7:0]);
        apb(1, OFF_UB_HI, ub[9:8]);
        apb(1, OFF_CTRL1, m << 3);
        apb(1, OFF_IRQ_EN, 32'h2);
        apb(1, OFF_IRQ_CLR, 32'h3);
        conv(3'h2);
        apb(0, OFF_IRQ_STAT, 0);
        chk("bound status", hit, rd[IRQ_BOUND_BIT]);
        chk("irq", hit, irq);
        apb(1, OFF_IRQ_CLR, 32'h3);
        @(posedge pclk);
        chk("irq cleared", 0, irq);
      end
    end
  endtask : t_bounds
  task automatic trig(input logic [7:0] c1, input logic [7:0] d, output int n);
    apb(1, OFF_CTRL1, c1);
    apb(1, OFF_DELAY, d);
    apb(1, OFF_IRQ_EN, 32'h1);
    apb(1, OFF_IRQ_CLR, 32'h3);
    @(posedge pclk);
    pwm_trigger <= 1'b1;
    @(posedge pclk);
    pwm_trigger <= 1'b0;
    n = 0;
    while (irq !== 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
  endtask : trig
  task automatic t_delay();
    int n0, n1;
    apb(1, OFF_CTRL0, 0);
    trig(8'h80, 8'h00, n0);
    trig(8'hC0, 8'h14, n1);
    chk("pwm start delay", 20, n1 - n0);
  endtask : t_delay
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_channels();
    t_regs();
    t_bounds();
    t_delay();
    close_out();
  end
endmodule : adc_result_and_control_regs_test

// >>> tb/conv_core_model.sv
`timescale 1ns/1ns
module conv_core_model (
  input  wire logic       pclk,       // system clock
  input  wire logic [2:0] chan,       // routed analog input
  input  wire logic       power_off,  // core powered down
  output logic      [9:0] core_data   // digitised value
);
  logic [9:0] last_ff = 10'h000;
  always @(posedge pclk) begin
    last_ff <= core_data;
  end
  // a powered-down core holds no stable value, so keep it moving
  assign core_data = power_off ? ~last_ff : {chan, 7'h2A};
endmodule : conv_core_model
